// *** inc/net_frame_pkg.sv ***
package net_frame_pkg;

  // ==========================================================================
  // Frame layout and coding constants
  // ==========================================================================
  localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
  localparam logic [7:0] FRAME_START_DELIMITER = 8'hD0;
  localparam logic [7:0] END_OF_FRAME_CHAR = 8'h04;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_RESET = 8'h00;
  localparam logic [7:0] STATION_ADDR_DEFAULT = 8'h01;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLOCK_HZ = 250000000;
  localparam int BIT_RATE_MIN = 9600;
  localparam int BIT_RATE_MAX = 1000000;
  localparam int BIT_RATE_DEFAULT = BIT_RATE_MAX;
  localparam int BIT_PERIOD_CYCLES = CLOCK_HZ / BIT_RATE_DEFAULT;
  localparam logic [3:0] JAM_BITS = 4'h8;
  localparam logic [3:0] BACKOFF_LAST = 4'hF;

  // ==========================================================================
  // Sizes
  // ==========================================================================
  localparam int BUF_DEPTH = 256;
  localparam int COUNT_WIDTH = 16;

  // ==========================================================================
  // States
  // ==========================================================================
  typedef enum logic [2:0] {
    TX_LOAD, TX_WAIT_IDLE, TX_SEND, TX_JAM, TX_BACKOFF
  } tx_state_e;

  typedef enum logic [1:0] {
    PH_PRE, PH_SFD, PH_BODY, PH_CRC
  } tx_phase_e;

  typedef enum logic [2:0] {
    RX_HUNT, RX_DEST, RX_BODY, RX_IGNORE, RX_DELIVER
  } rx_state_e;

endpackage

// *** core/crc8_lfsr.sv ***
`timescale 1ns/1ps
module crc8_lfsr
  import net_frame_pkg::*;
#(
  parameter logic [7:0] POLY = CRC_POLY
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Control
  input wire logic clear,
  input wire logic step,
  input wire logic din,
  // Result
  output logic [7:0] value
);

  typedef struct packed {
    logic [7:0] crc;
  } state_s;

  state_s s_reg;
  state_s s_next;

  // ==========================================================================
  // Shift register, one bit per step
  // ==========================================================================
  always_comb begin
    s_next = s_reg;
    if (clear) begin
      s_next.crc = CRC_RESET;
    end else if (step) begin
      s_next.crc = {s_reg.crc[6:0], 1'b0} ^ ((s_reg.crc[7] ^ din) ? POLY : 8'h00);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign value = s_reg.crc;

endmodule

// *** core/bit_rate_tick.sv ***
`timescale 1ns/1ps
module bit_rate_tick #(
  parameter int CYCLES = 250
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Enables
  output logic bit_tick,
  output logic mid_tick
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  localparam logic [CW-1:0] HALF = CW'(CYCLES / 2);

  typedef struct packed {
    logic [CW-1:0] count;
    logic bit_tick;
    logic mid_tick;
  } state_s;

  state_s s_reg;
  state_s s_next;

  // ==========================================================================
  // Free-running divider with end-of-bit and mid-bit pulses
  // ==========================================================================
  always_comb begin
    s_next = s_reg;
    s_next.count = (s_reg.count == LAST) ? '0 : s_reg.count + CW'(1);
    s_next.bit_tick = (s_reg.count == LAST);
    s_next.mid_tick = (s_reg.count == HALF);
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bit_tick = s_reg.bit_tick;
  assign mid_tick = s_reg.mid_tick;

endmodule

// *** core/shared_wire_frame_interface.sv ***
`timescale 1ns/1ps
module shared_wire_frame_interface
  import net_frame_pkg::*;
#(
  parameter logic [7:0] STATION_ADDR = STATION_ADDR_DEFAULT,
  parameter int BIT_CYCLES = BIT_PERIOD_CYCLES,
  parameter int DEPTH = BUF_DEPTH,
  parameter int CW = COUNT_WIDTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Configuration
  input wire logic crc_enable,
  // Host serial receiver side
  input wire logic [7:0] host_rx_data,
  input wire logic host_rx_valid,
  output logic host_rx_ready,
  // Host serial transmitter side
  output logic [7:0] host_tx_data,
  output logic host_tx_valid,
  input wire logic host_tx_ready,
  // Line side
  output logic line_data_out,
  output logic line_driver_enable,
  input wire logic line_echo,
  input wire logic carrier_detect,
  input wire logic rx_bit,
  input wire logic rx_bit_valid,
  input wire logic rx_error,
  // Statistics
  output logic [CW-1:0] collision_count,
  output logic [CW-1:0] error_count
);

  localparam int AW = $clog2(DEPTH);
  localparam int LW = AW + 1;
  localparam logic [LW-1:0] DEPTH_L = LW'(DEPTH);

  typedef struct packed {
    tx_state_e tx_state;
    tx_phase_e phase;
    logic [DEPTH-1:0][7:0] tx_mem;
    logic [LW-1:0] tx_len;
    logic [LW-1:0] tx_idx;
    logic [7:0] tx_sh;
    logic [2:0] tx_nbit;
    logic [3:0] jam_cnt;
    logic [3:0] backoff_cnt;
    logic line_bit;
    logic line_en;
    logic [CW-1:0] coll_cnt;
    rx_state_e rx_state;
    logic [DEPTH-1:0][7:0] rx_mem;
    logic [LW-1:0] rx_len;
    logic [LW-1:0] rx_idx;
    logic [7:0] rx_sh;
    logic [2:0] rx_nbit;
    logic [CW-1:0] err_cnt;
    logic [7:0] host_data;
    logic host_valid;
  } state_s;

  state_s s_reg;
  state_s s_next;

  logic bit_tick;
  logic mid_tick;
  logic tx_crc_clear;
  logic tx_crc_step;
  logic tx_crc_din;
  logic [7:0] tx_crc;
  logic rx_crc_clear;
  logic rx_crc_step;
  logic rx_crc_din;
  logic [7:0] rx_crc;

  // ==========================================================================
  // Bit timing and CRC engines
  // ==========================================================================
  // rate divider
  bit_rate_tick #(
    .CYCLES(BIT_CYCLES)
  ) u_tick (
    .clock(clock),
    .rst_b(rst_b),
    .bit_tick(bit_tick),
    .mid_tick(mid_tick)
  );

  crc8_lfsr u_tx_crc (
    .clock(clock),
    .rst_b(rst_b),
    .clear(tx_crc_clear),
    .step(tx_crc_step),
    .din(tx_crc_din),
    .value(tx_crc)
  );

  crc8_lfsr u_rx_crc (
    .clock(clock),
    .rst_b(rst_b),
    .clear(rx_crc_clear),
    .step(rx_crc_step),
    .din(rx_crc_din),
    .value(rx_crc)
  );

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    logic [7:0] nb;
    logic [LW-1:0] keep;
    nb = 8'h00;
    keep = '0;
    s_next = s_reg;
    tx_crc_clear = 1'b0;
    tx_crc_step = 1'b0;
    tx_crc_din = 1'b0;
    rx_crc_clear = 1'b0;
    rx_crc_step = 1'b0;
    rx_crc_din = 1'b0;

    if (bit_tick) begin
      s_next.backoff_cnt = s_reg.backoff_cnt + 4'h1;
    end

    case (s_reg.tx_state)
      TX_LOAD: begin
        if (host_rx_valid) begin
          if (host_rx_data == END_OF_FRAME_CHAR) begin
            if (s_reg.tx_len != '0) begin
              s_next.tx_state = TX_WAIT_IDLE;
            end
          end else if (s_reg.tx_len < DEPTH_L) begin
            s_next.tx_mem[s_reg.tx_len[AW-1:0]] = host_rx_data;
            s_next.tx_len = s_reg.tx_len + LW'(1);
          end
        end
      end
      TX_WAIT_IDLE: begin
        if (bit_tick && !carrier_detect) begin
          s_next.tx_state = TX_SEND;
          s_next.phase = PH_PRE;
          s_next.tx_sh = PREAMBLE_BYTE;
          s_next.tx_nbit = 3'h0;
          s_next.tx_idx = '0;
          s_next.line_bit = PREAMBLE_BYTE[0];
          s_next.line_en = 1'b1;
          tx_crc_clear = 1'b1;
        end
      end
      TX_SEND: begin
        if (mid_tick && (line_echo != s_reg.line_bit)) begin
          s_next.tx_state = TX_JAM;
          s_next.line_bit = 1'b0;
          s_next.jam_cnt = 4'h0;
          s_next.coll_cnt = s_reg.coll_cnt + CW'(1);
        end else if (bit_tick) begin
          if (s_reg.tx_nbit != 3'h7) begin
            s_next.tx_sh = {1'b0, s_reg.tx_sh[7:1]};
            s_next.tx_nbit = s_reg.tx_nbit + 3'h1;
            s_next.line_bit = s_reg.tx_sh[1];
            if (s_reg.phase == PH_CRC) begin
              s_next.line_bit = tx_crc[7];
              tx_crc_step = 1'b1;
              tx_crc_din = tx_crc[7];
            end else if (s_reg.phase == PH_BODY) begin
              // header, data and CRC bits feed the CRC, not preamble or SFD
              tx_crc_step = 1'b1;
              tx_crc_din = s_reg.tx_sh[1];
            end
          end else begin
            s_next.tx_nbit = 3'h0;
            case (s_reg.phase)
              PH_PRE: begin
                s_next.phase = PH_SFD;
                s_next.tx_sh = FRAME_START_DELIMITER;
                s_next.line_bit = FRAME_START_DELIMITER[0];
              end
              PH_SFD: begin
                nb = s_reg.tx_mem[0];
                s_next.phase = PH_BODY;
                s_next.tx_idx = '0;
                s_next.tx_sh = nb;
                s_next.line_bit = nb[0];
                tx_crc_step = 1'b1;
                tx_crc_din = nb[0];
              end
              PH_BODY: begin
                if (s_reg.tx_idx + LW'(1) < s_reg.tx_len) begin
                  nb = s_reg.tx_mem[s_reg.tx_idx[AW-1:0] + AW'(1)];
                  s_next.tx_idx = s_reg.tx_idx + LW'(1);
                  s_next.tx_sh = nb;
                  s_next.line_bit = nb[0];
                  tx_crc_step = 1'b1;
                  tx_crc_din = nb[0];
                end else if (crc_enable) begin
                  s_next.phase = PH_CRC;
                  s_next.line_bit = tx_crc[7];
                  tx_crc_step = 1'b1;
                  tx_crc_din = tx_crc[7];
                end else begin
                  s_next.tx_state = TX_LOAD;
                  s_next.tx_len = '0;
                  s_next.line_en = 1'b0;
                  s_next.line_bit = 1'b0;
                end
              end
              default: begin
                s_next.tx_state = TX_LOAD;
                s_next.tx_len = '0;
                s_next.line_en = 1'b0;
                s_next.line_bit = 1'b0;
              end
            endcase
          end
        end
      end
      TX_JAM: begin
        s_next.line_bit = 1'b0;
        if (bit_tick) begin
          s_next.jam_cnt = s_reg.jam_cnt + 4'h1;
          if (s_reg.jam_cnt == JAM_BITS) begin
            s_next.line_en = 1'b0;
            s_next.tx_state = TX_BACKOFF;
          end
        end
      end
      TX_BACKOFF: begin
        if (bit_tick && (s_reg.backoff_cnt == BACKOFF_LAST)) begin
          s_next.tx_state = TX_WAIT_IDLE;
        end
      end
      default: begin
        s_next.tx_state = TX_LOAD;
        s_next.line_en = 1'b0;
      end
    endcase

    case (s_reg.rx_state)
      RX_HUNT: begin
        if (rx_bit_valid) begin
          s_next.rx_sh = {rx_bit, s_reg.rx_sh[7:1]};
          if ({rx_bit, s_reg.rx_sh[7:1]} == FRAME_START_DELIMITER) begin
            s_next.rx_state = RX_DEST;
            s_next.rx_nbit = 3'h0;
            s_next.rx_len = '0;
            rx_crc_clear = 1'b1;
          end
        end
      end
      RX_DEST, RX_BODY: begin
        if (rx_error) begin
          s_next.rx_state = RX_IGNORE;
          s_next.err_cnt = s_reg.err_cnt + CW'(1);
        end else if (rx_bit_valid) begin
          nb = {rx_bit, s_reg.rx_sh[7:1]};
          s_next.rx_sh = nb;
          s_next.rx_nbit = s_reg.rx_nbit + 3'h1;
          // all header, data and CRC bits
          rx_crc_step = 1'b1;
          rx_crc_din = rx_bit;
          if (s_reg.rx_nbit == 3'h7) begin
            if (s_reg.rx_state == RX_DEST) begin
              s_next.rx_state = (nb == STATION_ADDR) ? RX_BODY : RX_IGNORE;
            end else if (s_reg.rx_len < DEPTH_L) begin
              s_next.rx_mem[s_reg.rx_len[AW-1:0]] = nb;
              s_next.rx_len = s_reg.rx_len + LW'(1);
            end else begin
              s_next.rx_state = RX_IGNORE;
              s_next.err_cnt = s_reg.err_cnt + CW'(1);
            end
          end
        end else if (!carrier_detect) begin
          keep = crc_enable ? s_reg.rx_len - LW'(1) : s_reg.rx_len;
          if ((s_reg.rx_state == RX_BODY) && (s_reg.rx_nbit == 3'h0) &&
              (s_reg.rx_len > (crc_enable ? LW'(1) : LW'(0))) &&
              (!crc_enable || (rx_crc == CRC_RESET))) begin
            s_next.rx_state = RX_DELIVER;
            s_next.rx_len = keep;
            s_next.rx_idx = '0;
          end else begin
            s_next.rx_state = RX_HUNT;
            s_next.rx_sh = 8'h00;
            s_next.err_cnt = s_reg.err_cnt + CW'(1);
          end
        end
      end
      RX_IGNORE: begin
        if (!carrier_detect) begin
          s_next.rx_state = RX_HUNT;
          s_next.rx_sh = 8'h00;
        end
      end
      RX_DELIVER: begin
        if (!s_reg.host_valid || host_tx_ready) begin
          if (s_reg.rx_idx < s_reg.rx_len) begin
            s_next.host_data = s_reg.rx_mem[s_reg.rx_idx[AW-1:0]];
            s_next.host_valid = 1'b1;
            s_next.rx_idx = s_reg.rx_idx + LW'(1);
          end else begin
            s_next.host_valid = 1'b0;
            s_next.rx_state = RX_IGNORE;
          end
        end
      end
      default: begin
        s_next.rx_state = RX_HUNT;
      end
    endcase
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign host_rx_ready = (s_reg.tx_state == TX_LOAD);
  assign host_tx_data = s_reg.host_data;
  assign host_tx_valid = s_reg.host_valid;
  assign line_data_out = s_reg.line_bit;
  assign line_driver_enable = s_reg.line_en;
  assign collision_count = s_reg.coll_cnt;
  assign error_count = s_reg.err_cnt;

endmodule

// *** verification/shared_wire_frame_interface_chk.sv ***
`timescale 1ns/1ps
module shared_wire_frame_interface_chk
  import net_frame_pkg::*;
#(
  parameter int CW = COUNT_WIDTH
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic crc_enable,
  input wire logic [7:0] host_rx_data,
  input wire logic host_rx_valid,
  input wire logic host_rx_ready,
  input wire logic [7:0] host_tx_data,
  input wire logic host_tx_valid,
  input wire logic host_tx_ready,
  input wire logic line_data_out,
  input wire logic line_driver_enable,
  input wire logic line_echo,
  input wire logic carrier_detect,
  input wire logic rx_bit,
  input wire logic rx_bit_valid,
  input wire logic rx_error,
  input wire logic [CW-1:0] collision_count,
  input wire logic [CW-1:0] error_count
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic [8:0] loaded_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      loaded_reg <= '0;
    end else if (!host_rx_ready) begin
      loaded_reg <= '0;
    end else if (host_rx_valid && (host_rx_data != END_OF_FRAME_CHAR)) begin
      loaded_reg <= loaded_reg + 9'h001;
    end
  end
  sequence s_start;
    $rose(line_driver_enable);
  endsequence
  sequence s_collide;
    $changed(collision_count);
  endsequence
  sequence s_jam;
    (line_driver_enable && !line_data_out) [*8];
  endsequence
  property p_coll_step;
    s_collide |-> collision_count - $past(collision_count) == CW'(1);
  endproperty
  a_coll_step: assert property (p_coll_step) else $error("collision count jumped");
  property p_err_step;
    $changed(error_count) |-> error_count - $past(error_count) == CW'(1);
  endproperty
  a_err_step: assert property (p_err_step) else $error("error count jumped");
  property p_jam;
    s_collide |-> s_jam;
  endproperty
  a_jam: assert property (p_jam) else $error("jam not low with driver on");
  property p_defer;
    s_start |-> !$past(carrier_detect);
  endproperty
  a_defer: assert property (p_defer) else $error("sent over busy line");
  property p_first_bit;
    s_start |-> line_data_out;
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("first line bit wrong");
  property p_en_min;
    s_start |-> line_driver_enable [*8];
  endproperty
  a_en_min: assert property (p_en_min) else $error("driver enable too short");
  property p_no_load;
    line_driver_enable |-> !host_rx_ready;
  endproperty
  a_no_load: assert property (p_no_load) else $error("loading while sending");
  property p_eof;
    host_rx_valid && host_rx_ready && host_rx_data == END_OF_FRAME_CHAR && loaded_reg != 9'h000
      |=> !host_rx_ready;
  endproperty
  a_eof: assert property (p_eof) else $error("end of frame did not stop loading");
  property p_tx_hold;
    host_tx_valid && !host_tx_ready |=> host_tx_valid && $stable(host_tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("host byte dropped");
endmodule

bind shared_wire_frame_interface shared_wire_frame_interface_chk #(.CW(CW)) chk_u (.*);

// *** verification/line_station_model.sv ***
`timescale 1ns/1ps
module line_station_model
  import net_frame_pkg::*;
#(
  parameter int BIT_CYCLES = 8
) (
  // Clock
  input wire logic clock,
  // From the station
  input wire logic line_data_out,
  input wire logic line_driver_enable,
  // To the station
  output logic line_echo,
  output logic carrier_detect,
  output logic rx_bit,
  output logic rx_bit_valid,
  output logic rx_error
);
  logic collide = 1'b0;
  logic noise = 1'b0;
  initial begin
    carrier_detect = 1'b0;
    rx_bit = 1'b0;
    rx_bit_valid = 1'b0;
    rx_error = 1'b0;
  end
  always @(negedge clock) begin
    noise <= ~noise;
  end
  assign line_echo = line_driver_enable ? (line_data_out ^ collide) : noise;
  function automatic logic [7:0] crc_of(input logic [7:0] q[$]);
    logic [7:0] c;
    c = CRC_RESET;
    foreach (q[i]) begin
      for (int k = 0; k < 8; k++) begin
        c = {c[6:0], 1'b0} ^ ((q[i][k] ^ c[7]) ? CRC_POLY : 8'h00);
      end
    end
    return c;
  endfunction
  task automatic send_bit(input logic b);
    repeat (BIT_CYCLES - 1) @(negedge clock);
    rx_bit = b;
    rx_bit_valid = 1'b1;
    @(negedge clock);
    rx_bit_valid = 1'b0;
    rx_bit = ~b;
  endtask
  // frame order, lsb first, CRC from top stage
  task automatic send_frame(input logic [7:0] q[$], input logic add_crc, input logic bad,
                            input int err_at);
    logic [7:0] c;
    c = crc_of(q) ^ (bad ? 8'h01 : 8'h00);
    @(negedge clock);
    carrier_detect = 1'b1;
    for (int k = 0; k < 8; k++) send_bit(PREAMBLE_BYTE[k]);
    for (int k = 0; k < 8; k++) send_bit(FRAME_START_DELIMITER[k]);
    foreach (q[i]) begin
      if (i == err_at) begin
        rx_error = 1'b1;
        @(negedge clock);
        rx_error = 1'b0;
      end
      for (int k = 0; k < 8; k++) send_bit(q[i][k]);
    end
    if (add_crc) for (int k = 7; k >= 0; k--) send_bit(c[k]);
    repeat (BIT_CYCLES) @(negedge clock);
    carrier_detect = 1'b0;
  endtask
endmodule

// *** verification/shared_wire_frame_interface_bench.sv ***
`timescale 1ns/1ps
module shared_wire_frame_interface_bench;
  import net_frame_pkg::*;
  localparam int BC = 8;
  localparam logic [7:0] ME = 8'h5A;
  logic clock, rst_b, crc_enable, host_rx_valid, host_rx_ready, host_tx_valid, host_tx_ready;
  logic [7:0] host_rx_data, host_tx_data;
  logic line_data_out, line_driver_enable, line_echo, carrier_detect;
  logic rx_bit, rx_bit_valid, rx_error;
  logic [15:0] collision_count, error_count;
  int n_fail = 0;
  int n_compared = 0;
  logic bits[$];
  logic [7:0] got[$];
  shared_wire_frame_interface #(.STATION_ADDR(ME), .BIT_CYCLES(BC), .DEPTH(16)) dut_u (.*);
  line_station_model #(.BIT_CYCLES(BC)) partner_u (.*);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================================
  // Transmit helpers
  // ==========================================================================
  task automatic load(input logic [7:0] q[$]);
    foreach (q[i]) begin
      @(negedge clock);
      host_rx_data = q[i];
      host_rx_valid = 1'b1;
    end
    @(negedge clock);
    host_rx_data = END_OF_FRAME_CHAR;
    @(negedge clock);
    host_rx_valid = 1'b0;
  endtask
  task automatic capture;
    for (int i = 0; i < 5000 && !line_driver_enable; i++) @(negedge clock);
    bits.delete();
    repeat (BC / 2) @(negedge clock);
    while (line_driver_enable && bits.size() < 400) begin
      bits.push_back(line_data_out);
      repeat (BC) @(negedge clock);
    end
  endtask
  task automatic judge(input logic [7:0] q[$], input logic crc_on);
    logic [7:0] all[$];
    logic c;
    all = {PREAMBLE_BYTE, FRAME_START_DELIMITER};
    all = {all, q};
    check(bits.size(), 8 * all.size() + (crc_on ? 8 : 0), "bit count");
    foreach (all[i]) for (int k = 0; k < 8; k++) begin
      c = (8 * i + k < bits.size()) ? bits[8 * i + k] : 1'bx;
      check(c, all[i][k], "frame bit");
    end
    if (crc_on && bits.size() == 8 * all.size() + 8) begin
      for (int k = 0; k < 8; k++) begin
        check(bits[8 * all.size() + k], partner_u.crc_of(q) >> (7 - k) & 1, "crc bit");
      end
    end
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_tx(input logic crc_on);
    crc_enable = crc_on;
    partner_u.carrier_detect = 1'b1;
    load('{8'h02, ME, 8'hA5, 8'h3C});
    check(host_rx_ready, 1'b0, "loading stopped");
    repeat (60) @(negedge clock);
    check(line_driver_enable, 1'b0, "deferred");
    partner_u.carrier_detect = 1'b0;
    capture();
    judge('{8'h02, ME, 8'hA5, 8'h3C}, crc_on);
    check(line_driver_enable, 1'b0, "released");
    $display("test tx crc=%0d done", crc_on);
  endtask
  task automatic t_collide;
    logic [15:0] c0;
    c0 = collision_count;
    crc_enable = 1'b1;
    partner_u.collide = 1'b1;
    load('{8'h07, ME, 8'h99});
    for (int i = 0; i < 2000 && collision_count === c0; i++) @(negedge clock);
    partner_u.collide = 1'b0;
    check(collision_count, c0 + 16'h0001, "collision counted");
    check(line_data_out, 1'b0, "jam level");
    for (int i = 0; i < 2000 && line_driver_enable; i++) @(negedge clock);
    capture();
    judge('{8'h07, ME, 8'h99}, 1'b1);
    check(collision_count, c0 + 16'h0001, "one collision");
    $display("test collision done");
  endtask
  task automatic t_rx(input logic [7:0] dest, input logic crc_on, input logic bad,
                      input int err_at, input int n_deliver, input int n_err);
    logic [15:0] e0;
    e0 = error_count;
    crc_enable = crc_on;
    got.delete();
    host_tx_ready = 1'b0;
    partner_u.send_frame('{dest, 8'h33, 8'h11, 8'h22}, crc_on, bad, err_at);
    repeat (300) begin
      @(negedge clock);
      host_tx_ready = ~host_tx_ready;
      if (host_tx_valid && host_tx_ready) got.push_back(host_tx_data);
    end
    check(got.size(), n_deliver, "delivered count");
    if (n_deliver == 3 && got.size() == 3) begin
      check({got[0], got[1], got[2]}, 24'h331122, "delivered bytes");
    end
    check(error_count, e0 + 16'(n_err), "error count");
    $display("test rx dest=%h crc=%0d bad=%0d done", dest, crc_on, bad);
  endtask
  initial begin
    #200000;
    n_fail++;
    end_sim();
  end
  initial begin
    rst_b = 1'b0;
    crc_enable = 1'b1;
    host_rx_data = 8'h00;
    host_rx_valid = 1'b0;
    host_tx_ready = 1'b0;
    repeat (4) @(negedge clock);
    rst_b = 1'b1;
    check({collision_count, error_count}, 32'h0, "reset counts");
    check({host_rx_ready, line_driver_enable}, 2'b10, "reset state");
    t_tx(1'b1);
    t_tx(1'b0);
    t_collide();
    t_rx(ME, 1'b1, 1'b0, -1, 3, 0);
    t_rx(ME, 1'b0, 1'b1, -1, 3, 0);
    t_rx(8'h77, 1'b1, 1'b0, -1, 0, 0);
    t_rx(ME, 1'b1, 1'b1, -1, 0, 1);
    t_rx(ME, 1'b1, 1'b0, 2, 0, 1);
    t_rx(ME, 1'b1, 1'b0, -1, 3, 0);
    end_sim();
  end
endmodule
